/* File: verilog/tsc_pkg.sv */
`default_nettype none
package tsc_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned PULSE_UNIT_NS = 1000;
  localparam int unsigned CYC_PER_US = PULSE_UNIT_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------------------
  localparam logic [15:0] OUTPUT_PULSE_LENGTH_RST = 16'h0019;
  localparam logic [15:0] WLEN_MIN = 16'h04ec;
  localparam logic [15:0] WLEN_MAX = 16'h0672;
  localparam logic [15:0] WLEN_RST = 16'h060e;
  localparam logic [15:0] MASK_RST = 16'h0000;

  // ---------------------------------------------------------------------------
  // Field encodings
  // ---------------------------------------------------------------------------
  localparam logic EDGE_FALL = 1'b0;
  localparam logic EDGE_RISE = 1'b1;
  localparam logic [1:0] POS_ZERO = 2'h0;
  localparam logic [1:0] POS_MIN = 2'h1;
  localparam logic [1:0] POS_MAX = 2'h2;
  localparam logic [1:0] UNIT_VOLT = 2'h0;
  localparam logic [1:0] UNIT_RAD = 2'h1;
  localparam logic [1:0] UNIT_PI = 2'h2;

  typedef enum logic [4:0] {
    OP_IN_STATE_SET = 5'b00000,
    OP_IN_STATE_Q = 5'b00001,
    OP_IN_TYPE_SET = 5'b00010,
    OP_IN_TYPE_Q = 5'b00011,
    OP_IN_CNT_Q = 5'b00100,
    OP_IN_CNT_CLR = 5'b00101,
    OP_OUT_STATE_SET = 5'b00110,
    OP_OUT_STATE_Q = 5'b00111,
    OP_OUT_TYPE_SET = 5'b01000,
    OP_OUT_TYPE_Q = 5'b01001,
    OP_OUT_CNT_Q = 5'b01010,
    OP_OUT_CNT_CLR = 5'b01011,
    OP_OUTPUT_PULSE_LENGTH_SET = 5'b01100,
    OP_OUTPUT_PULSE_LENGTH_Q = 5'b01101,
    OP_CHPOS_SET = 5'b01110,
    OP_CHPOS_Q = 5'b01111,
    OP_LOCK_SET = 5'b10000,
    OP_LOCK_Q = 5'b10001,
    OP_WLEN_SET = 5'b10010,
    OP_WLEN_Q = 5'b10011,
    OP_UNIT_SET = 5'b10100,
    OP_UNIT_Q = 5'b10101,
    OP_ABORT = 5'b10110,
    OP_PAUSE = 5'b10111,
    OP_RESTART = 5'b11000,
    OP_MODE_Q = 5'b11001,
    OP_ANOM_EVT_Q = 5'b11010,
    OP_ANOM_MASK_SET = 5'b11011,
    OP_ANOM_MASK_Q = 5'b11100,
    OP_ACT_MASK_SET = 5'b11101,
    OP_ACT_MASK_Q = 5'b11110,
    OP_ACT_EVT_Q = 5'b11111
  } tsc_op_t;

  typedef enum logic [1:0] {
    FN_STOPPED = 2'b00,
    FN_RUNNING = 2'b01,
    FN_PAUSED = 2'b10
  } tsc_func_t;

endpackage
`default_nettype wire

/* File: verilog/tsc_top.sv */
// Functional notes
// R01 - Input trigger accepted only while enabled; off default.
// R02 - Input edge rising or falling, falling default, readable.
// R03 - Input trigger event counter queryable any time.
// R04 - Input counter clear command zeroes it.
// R05 - Output pulses only while enabled; off default.
// R06 - Output pulse rising or falling, falling default.
// R07 - Emitted output pulses counted and queryable.
// R08 - Output counter clear command zeroes it.
// R09 - Pulse width 0-65535 us, default 25, readable.
// R10 - Per channel trigger at max or min/zero.
// R11 - Display lock shows remote message, else function.
// R12 - Wavelength 1260-1650 nm stored and returned.
// R13 - One unit selection: volts, radians, pi; volts default.
// R14 - Current mode reported as code 0 to 8.
// R15 - Anomaly event flags read returns and clears.
// R16 - Anomaly enable mask 16 bits, writable, readable.
// R17 - Activity enable mask 16 bits, writable, readable.
// R18 - Activity event register returned on query.
// R19 - Counters step once per event, only when enabled.
// R20 - Stop halts, pause freezes, restart starts afresh.
`default_nettype none
module tsc_top #(
  parameter int unsigned N_CH = 4,
  parameter int unsigned CNT_W = 32
) (
  input wire logic core_clk, // System clock, 25 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic cmd_valid, // One-cycle command strobe.
  input wire logic [4:0] cmd_op, // Command code.
  input wire logic [15:0] cmd_arg, // Command argument.
  input wire logic [$clog2(N_CH)-1:0] cmd_chan, // Channel for position commands.
  input wire logic trig_in_pin, // External trigger pin, asynchronous.
  input wire logic [N_CH-1:0] wave_max_hit, // Waveform at maximum, per channel.
  input wire logic [N_CH-1:0] wave_min_hit, // Waveform at minimum, per channel.
  input wire logic [3:0] mode_code, // Current system mode code.
  input wire logic [15:0] anom_evt, // Anomaly event pulses.
  input wire logic [15:0] act_evt, // Activity event pulses.
  output logic rsp_valid, // One-cycle answer strobe.
  output logic [31:0] rsp_data, // Answer data.
  output logic rsp_err, // Command refused.
  output logic trig_out_pin, // Trigger output pin.
  output logic disp_remote, // Display shows remote message.
  output logic [1:0] unit_sel, // Unit selection.
  output logic [15:0] wavelength_nm, // Operating wavelength.
  output logic func_run, // Current function running.
  output logic func_restart, // One-cycle restart pulse.
  output logic anom_summary, // Enabled anomaly flag present.
  output logic act_summary // Enabled activity flag present.
);

  // ---------------------------------------------------------------------------
  // Command decode and settings
  // ---------------------------------------------------------------------------
  logic in_en_q, in_rise_q, out_en_q, out_rise_q, lock_q;
  logic [15:0] output_pulse_length_q, wlen_q, anom_mask_q, act_mask_q, anom_flags_q, act_flags_q;
  logic [1:0] unit_q;
  logic [1:0] chpos_q [N_CH];
  logic [3:0] mode_q;
  logic [CNT_W-1:0] in_cnt_q, out_cnt_q;
  tsc_pkg::tsc_func_t func_q;
  logic func_restart_q, func_run_q;
  logic rsp_valid_q, rsp_err_q;
  logic [31:0] rsp_data_q;
  logic [31:0] rsp_data_d;
  logic rsp_err_d;

  function automatic logic is_op(input logic v, input logic [4:0] op, input tsc_pkg::tsc_op_t want);
    return v && (op == want);
  endfunction

  logic wlen_ok, unit_ok, pos_ok;
  assign wlen_ok = (cmd_arg >= tsc_pkg::WLEN_MIN) && (cmd_arg <= tsc_pkg::WLEN_MAX);
  assign unit_ok = cmd_arg[15:0] <= {14'h0000, tsc_pkg::UNIT_PI};
  assign pos_ok = cmd_arg[15:0] <= {14'h0000, tsc_pkg::POS_MAX};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      in_en_q <= 1'b0; // R01
      in_rise_q <= tsc_pkg::EDGE_FALL; // R02
      out_en_q <= 1'b0; // R05
      out_rise_q <= tsc_pkg::EDGE_FALL; // R06
      output_pulse_length_q <= tsc_pkg::OUTPUT_PULSE_LENGTH_RST; // R09
    end else begin
      if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_IN_STATE_SET)) begin
        in_en_q <= cmd_arg[0]; // R01
      end
      if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_IN_TYPE_SET)) begin
        in_rise_q <= cmd_arg[0]; // R02
      end
      if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_OUT_STATE_SET)) begin
        out_en_q <= cmd_arg[0]; // R05
      end
      if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_OUT_TYPE_SET)) begin
        out_rise_q <= cmd_arg[0]; // R06
      end
      if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_OUTPUT_PULSE_LENGTH_SET)) begin
        output_pulse_length_q <= cmd_arg; // R09
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < N_CH; i++) begin
        chpos_q[i] <= tsc_pkg::POS_ZERO; // R10
      end
    end else if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_CHPOS_SET) && pos_ok) begin
      chpos_q[cmd_chan] <= cmd_arg[1:0]; // R10
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lock_q <= 1'b0;
      wlen_q <= tsc_pkg::WLEN_RST;
      unit_q <= tsc_pkg::UNIT_VOLT; // R13
      anom_mask_q <= tsc_pkg::MASK_RST;
      act_mask_q <= tsc_pkg::MASK_RST;
      mode_q <= 4'h0;
    end else begin
      mode_q <= mode_code; // R14
      if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_LOCK_SET)) begin
        lock_q <= cmd_arg[0]; // R11
      end
      if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_WLEN_SET) && wlen_ok) begin
        wlen_q <= cmd_arg; // R12
      end
      if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_UNIT_SET) && unit_ok) begin
        unit_q <= cmd_arg[1:0]; // R13
      end
      if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_ANOM_MASK_SET)) begin
        anom_mask_q <= cmd_arg; // R16
      end
      if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_ACT_MASK_SET)) begin
        act_mask_q <= cmd_arg; // R17
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Current function control
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      func_q <= tsc_pkg::FN_RUNNING;
      func_restart_q <= 1'b0;
      func_run_q <= 1'b1;
    end else begin
      func_restart_q <= is_op(cmd_valid, cmd_op, tsc_pkg::OP_RESTART); // R20
      func_run_q <= (func_q == tsc_pkg::FN_RUNNING)
        ? !(is_op(cmd_valid, cmd_op, tsc_pkg::OP_ABORT) || is_op(cmd_valid, cmd_op, tsc_pkg::OP_PAUSE))
        : (func_q inside {tsc_pkg::FN_PAUSED, tsc_pkg::FN_STOPPED})
          && is_op(cmd_valid, cmd_op, tsc_pkg::OP_RESTART); // R20
      case (func_q)
        tsc_pkg::FN_RUNNING: begin
          if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_ABORT)) begin
            func_q <= tsc_pkg::FN_STOPPED; // R20
          end else if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_PAUSE)) begin
            func_q <= tsc_pkg::FN_PAUSED; // R20
          end
        end
        tsc_pkg::FN_PAUSED, tsc_pkg::FN_STOPPED: begin
          if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_RESTART)) begin
            func_q <= tsc_pkg::FN_RUNNING; // R20
          end else if (is_op(cmd_valid, cmd_op, tsc_pkg::OP_ABORT)) begin
            func_q <= tsc_pkg::FN_STOPPED; // R20
          end
        end
        default: begin
          func_q <= tsc_pkg::FN_STOPPED;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Input trigger
  // ---------------------------------------------------------------------------
  logic sync1_q, sync2_q, sync3_q, in_filt_q;
  logic in_hit, in_clr;
  assign in_hit = in_en_q && (sync2_q == sync3_q) && (sync3_q != in_filt_q) && (sync3_q == in_rise_q); // R01
  assign in_clr = is_op(cmd_valid, cmd_op, tsc_pkg::OP_IN_CNT_CLR);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      in_filt_q <= 1'b0;
    end else begin
      sync1_q <= trig_in_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        in_filt_q <= sync3_q; // R02
      end
    end
  end

  // A clear in the same cycle as an accepted edge leaves a count of one.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      in_cnt_q <= '0;
    end else if (in_clr) begin
      in_cnt_q <= in_hit ? CNT_W'(1) : '0; // R04
    end else if (in_hit) begin
      in_cnt_q <= in_cnt_q + CNT_W'(1); // R19
    end
  end

  // ---------------------------------------------------------------------------
  // Output trigger
  // ---------------------------------------------------------------------------
  localparam logic [4:0] US_LAST = 5'(tsc_pkg::CYC_PER_US - 1);
  logic out_active_q, trig_out_q;
  logic [4:0] out_pre_q;
  logic [15:0] out_left_q;
  logic [N_CH-1:0] ch_hit;
  logic out_start, out_clr;

  always_comb begin
    for (int i = 0; i < N_CH; i++) begin
      ch_hit[i] = (chpos_q[i] == tsc_pkg::POS_MAX) ? wave_max_hit[i] : wave_min_hit[i]; // R10
    end
  end

  assign out_start = out_en_q && !out_active_q && (|ch_hit) && (output_pulse_length_q != 16'h0000); // R05
  assign out_clr = is_op(cmd_valid, cmd_op, tsc_pkg::OP_OUT_CNT_CLR);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_active_q <= 1'b0;
      out_pre_q <= 5'h00;
      out_left_q <= 16'h0000;
    end else if (out_start) begin
      out_active_q <= 1'b1;
      out_pre_q <= 5'h00;
      out_left_q <= output_pulse_length_q; // R09
    end else if (out_active_q) begin
      if (out_pre_q == US_LAST) begin
        out_pre_q <= 5'h00;
        out_left_q <= out_left_q - 16'h0001;
        if (out_left_q == 16'h0001) begin
          out_active_q <= 1'b0; // R09
        end
      end else begin
        out_pre_q <= out_pre_q + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      trig_out_q <= ~tsc_pkg::EDGE_FALL;
    end else begin
      trig_out_q <= out_start || (out_active_q && !(out_pre_q == US_LAST && out_left_q == 16'h0001))
        ? out_rise_q : ~out_rise_q; // R06
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_cnt_q <= '0;
    end else if (out_clr) begin
      out_cnt_q <= out_start ? CNT_W'(1) : '0; // R08
    end else if (out_start) begin
      out_cnt_q <= out_cnt_q + CNT_W'(1); // R07
    end
  end

  // ---------------------------------------------------------------------------
  // Status event registers
  // ---------------------------------------------------------------------------
  logic anom_rd, act_rd, anom_sum_q, act_sum_q;
  assign anom_rd = is_op(cmd_valid, cmd_op, tsc_pkg::OP_ANOM_EVT_Q);
  assign act_rd = is_op(cmd_valid, cmd_op, tsc_pkg::OP_ACT_EVT_Q);

  // New events in the read cycle survive the read clear.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      anom_flags_q <= 16'h0000;
      act_flags_q <= 16'h0000;
      anom_sum_q <= 1'b0;
      act_sum_q <= 1'b0;
    end else begin
      anom_flags_q <= (anom_rd ? 16'h0000 : anom_flags_q) | anom_evt; // R15
      act_flags_q <= (act_rd ? 16'h0000 : act_flags_q) | act_evt; // R18
      anom_sum_q <= |(anom_flags_q & anom_mask_q); // R16
      act_sum_q <= |(act_flags_q & act_mask_q); // R17
    end
  end

  // ---------------------------------------------------------------------------
  // Answers
  // ---------------------------------------------------------------------------
  always_comb begin
    rsp_data_d = 32'h0000_0000;
    rsp_err_d = 1'b0;
    case (cmd_op)
      tsc_pkg::OP_IN_STATE_Q: rsp_data_d = {31'h0000_0000, in_en_q};
      tsc_pkg::OP_IN_TYPE_Q: rsp_data_d = {31'h0000_0000, in_rise_q}; // R02
      tsc_pkg::OP_IN_CNT_Q: rsp_data_d = 32'(in_cnt_q); // R03
      tsc_pkg::OP_OUT_STATE_Q: rsp_data_d = {31'h0000_0000, out_en_q};
      tsc_pkg::OP_OUT_TYPE_Q: rsp_data_d = {31'h0000_0000, out_rise_q}; // R06
      tsc_pkg::OP_OUT_CNT_Q: rsp_data_d = 32'(out_cnt_q); // R07
      tsc_pkg::OP_OUTPUT_PULSE_LENGTH_Q: rsp_data_d = {16'h0000, output_pulse_length_q}; // R09
      tsc_pkg::OP_CHPOS_Q: rsp_data_d = {30'h0000_0000, chpos_q[cmd_chan]}; // R10
      tsc_pkg::OP_LOCK_Q: rsp_data_d = {31'h0000_0000, lock_q};
      tsc_pkg::OP_WLEN_Q: rsp_data_d = {16'h0000, wlen_q}; // R12
      tsc_pkg::OP_UNIT_Q: rsp_data_d = {30'h0000_0000, unit_q};
      tsc_pkg::OP_MODE_Q: rsp_data_d = {28'h000_0000, mode_q}; // R14
      tsc_pkg::OP_ANOM_EVT_Q: rsp_data_d = {16'h0000, anom_flags_q}; // R15
      tsc_pkg::OP_ANOM_MASK_Q: rsp_data_d = {16'h0000, anom_mask_q}; // R16
      tsc_pkg::OP_ACT_MASK_Q: rsp_data_d = {16'h0000, act_mask_q}; // R17
      tsc_pkg::OP_ACT_EVT_Q: rsp_data_d = {16'h0000, act_flags_q}; // R18
      tsc_pkg::OP_WLEN_SET: rsp_err_d = !wlen_ok; // R12
      tsc_pkg::OP_UNIT_SET: rsp_err_d = !unit_ok;
      tsc_pkg::OP_CHPOS_SET: rsp_err_d = !pos_ok;
      default: rsp_err_d = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 32'h0000_0000;
      rsp_err_q <= 1'b0;
    end else begin
      rsp_valid_q <= cmd_valid;
      rsp_data_q <= cmd_valid ? rsp_data_d : 32'h0000_0000;
      rsp_err_q <= cmd_valid && rsp_err_d;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign rsp_err = rsp_err_q;
  assign trig_out_pin = trig_out_q;
  assign disp_remote = lock_q; // R11
  assign unit_sel = unit_q;
  assign wavelength_nm = wlen_q;
  assign func_run = func_run_q;
  assign func_restart = func_restart_q;
  assign anom_summary = anom_sum_q;
  assign act_summary = act_sum_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [31:0] hc_q, tgt_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hc_q <= 32'h0000_0000;
      tgt_q <= 32'h0000_0000;
    end else if (out_start) begin
      hc_q <= 32'h0000_0000;
      tgt_q <= 32'(output_pulse_length_q) * tsc_pkg::CYC_PER_US;
    end else if (out_active_q) begin
      hc_q <= hc_q + 32'h0000_0001;
    end
  end

  AST_IN_OFF_HOLDS: assert property (!in_en_q && !in_clr |=> $stable(in_cnt_q)) // R01
    else $error("Input counter moved while input trigger disabled.");
  AST_IN_STEP: assert property (in_hit && !in_clr |=> in_cnt_q == $past(in_cnt_q) + CNT_W'(1)) // R03
    else $error("Input counter did not step by one.");
  AST_IN_CLEAR: assert property (in_clr && !in_hit |=> in_cnt_q == '0) // R04
    else $error("Input counter not cleared.");
  AST_OUT_IDLE_LEVEL: assert property (!out_en_q && !out_active_q |=> trig_out_q == !$past(out_rise_q)) // R05
    else $error("Output trigger left idle level while disabled.");
  AST_OUT_PULSE_LEVEL: assert property (out_start |=> trig_out_q == $past(out_rise_q)) // R06
    else $error("Output pulse has wrong polarity.");
  AST_PULSE_LEN: assert property ($fell(out_active_q) |-> hc_q == tgt_q) // R09
    else $error("Output pulse length differs from programmed width.");
  AST_OUT_STEP: assert property (out_start && !out_clr |=> out_cnt_q == $past(out_cnt_q) + CNT_W'(1)) // R07
    else $error("Output counter did not step by one.");
  AST_OUT_CLEAR: assert property (out_clr && !out_start |=> out_cnt_q == '0) // R08
    else $error("Output counter not cleared.");
  AST_WLEN_RANGE: assert property (wlen_q >= tsc_pkg::WLEN_MIN && wlen_q <= tsc_pkg::WLEN_MAX) // R12
    else $error("Wavelength outside legal range.");
  AST_ANOM_RC: assert property (anom_rd ##1 (anom_evt == 16'h0000 && !anom_rd) |=> $past(anom_evt, 2) == anom_flags_q) // R15
    else $error("Anomaly flags not cleared by read.");
  AST_ABORT_STOPS: assert property (is_op(cmd_valid, cmd_op, tsc_pkg::OP_ABORT) |=> !func_run) // R20
    else $error("Abort did not stop current function.");
  AST_LOCK_SHOWN: assert property (is_op(cmd_valid, cmd_op, tsc_pkg::OP_LOCK_SET) |=> disp_remote == $past(cmd_arg[0])) // R11
    else $error("Display lock not applied.");

  COV_IN_HIT: cover property (in_hit);
  COV_OUT_PULSE: cover property ($fell(out_active_q));
  COV_RESTART: cover property (func_restart_q);
  COV_ANOM_READ: cover property (anom_rd && anom_flags_q != 16'h0000);

endmodule
`default_nettype wire

/* File: tb/tsc_host.sv */
`default_nettype none
module tsc_host (
  input wire logic core_clk, // Clock shared with the block.
  output logic cmd_valid, // Command strobe.
  output logic [4:0] cmd_op, // Command code.
  output logic [15:0] cmd_arg, // Command argument.
  output logic [1:0] cmd_chan, // Channel index.
  input wire logic rsp_valid, // Answer strobe.
  input wire logic [31:0] rsp_data, // Answer data.
  input wire logic rsp_err // Refusal flag.
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_valid = 1'b0;
    cmd_op = 5'h00;
    cmd_arg = 16'h0000;
    cmd_chan = 2'h0;
  end

  // Idle qualifiers are inverted so a stale value is never mistaken for a command.
  task automatic xfer(input logic [4:0] op, input logic [15:0] arg, input logic [1:0] ch,
                      output logic [31:0] d, output logic e);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_arg = arg;
    cmd_chan = ch;
    @(negedge core_clk);
    d = (rsp_valid === 1'b1) ? rsp_data : 32'hxxxx_xxxx;
    e = (rsp_valid === 1'b1) ? rsp_err : 1'bx;
    cmd_valid = 1'b0;
    cmd_op = ~op;
    cmd_arg = ~arg;
    cmd_chan = ~ch;
  endtask
endmodule
`default_nettype wire

/* File: tb/test_trigger_status_control.sv */
`default_nettype none
module test_trigger_status_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, rsp_valid, rsp_err, trig_out_pin, disp_remote, func_run, func_restart;
  logic anom_summary, act_summary;
  logic [4:0] cmd_op;
  logic [15:0] cmd_arg, wavelength_nm;
  logic [1:0] cmd_chan, unit_sel;
  logic [31:0] rsp_data;
  logic trig_in_pin = 1'b0;
  logic [3:0] wave_max_hit = 4'h0;
  logic [3:0] wave_min_hit = 4'h0;
  logic [3:0] mode_code = 4'h0;
  logic [15:0] anom_evt = 16'h0000;
  logic [15:0] act_evt = 16'h0000;
  int fails = 0;
  int num_checks = 0;

  always #20 core_clk = ~core_clk;

  tsc_host i_host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg(cmd_arg),
    .cmd_chan(cmd_chan), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err));

  tsc_top i_dut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_arg(cmd_arg), .cmd_chan(cmd_chan), .trig_in_pin(trig_in_pin), .wave_max_hit(wave_max_hit),
    .wave_min_hit(wave_min_hit), .mode_code(mode_code), .anom_evt(anom_evt), .act_evt(act_evt),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err), .trig_out_pin(trig_out_pin),
    .disp_remote(disp_remote), .unit_sel(unit_sel), .wavelength_nm(wavelength_nm), .func_run(func_run),
    .func_restart(func_restart), .anom_summary(anom_summary), .act_summary(act_summary));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmd(input logic [4:0] op, input logic [15:0] arg, input logic [1:0] ch,
                     input logic [31:0] exp_d, input logic exp_e);
    logic [31:0] d;
    logic e;
    i_host.xfer(op, arg, ch, d, e);
    check(d, exp_d);
    check({31'h0, e}, {31'h0, exp_e});
  endtask

  task automatic pin_edge(input logic v);
    @(negedge core_clk);
    trig_in_pin = v;
    repeat (4) @(negedge core_clk);
  endtask

  task automatic fire(input logic at_max, input int ch);
    @(negedge core_clk);
    if (at_max) wave_max_hit[ch] = 1'b1;
    else wave_min_hit[ch] = 1'b1;
    @(negedge core_clk);
    wave_max_hit = 4'h0;
    wave_min_hit = 4'h0;
  endtask

  task automatic pulse_len(input logic lvl, output int n);
    n = 0;
    for (int i = 0; i < 8 && trig_out_pin !== lvl; i++) @(negedge core_clk);
    while (trig_out_pin === lvl && n < 200) begin
      n++;
      @(negedge core_clk);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic test_defaults;
    cmd(tsc_pkg::OP_IN_STATE_Q, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_IN_TYPE_Q, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_OUT_STATE_Q, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_OUT_TYPE_Q, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_OUTPUT_PULSE_LENGTH_Q, 16'h0000, 2'h0, 32'h0000_0019, 1'b0);
    cmd(tsc_pkg::OP_CHPOS_Q, 16'h0000, 2'h3, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_UNIT_Q, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_ANOM_MASK_Q, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_ACT_MASK_Q, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    check({31'h0, trig_out_pin}, 32'h0000_0001);
    check({31'h0, disp_remote}, 32'h0000_0000);
  endtask

  task automatic test_input;
    pin_edge(1'b1);
    pin_edge(1'b0);
    cmd(tsc_pkg::OP_IN_CNT_Q, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_IN_STATE_SET, 16'h0001, 2'h0, 32'h0000_0000, 1'b0);
    pin_edge(1'b1);
    pin_edge(1'b0);
    cmd(tsc_pkg::OP_IN_CNT_Q, 16'h0000, 2'h0, 32'h0000_0001, 1'b0);
    cmd(tsc_pkg::OP_IN_TYPE_SET, 16'h0001, 2'h0, 32'h0000_0000, 1'b0);
    pin_edge(1'b1);
    pin_edge(1'b0);
    cmd(tsc_pkg::OP_IN_CNT_Q, 16'h0000, 2'h0, 32'h0000_0002, 1'b0);
    cmd(tsc_pkg::OP_IN_TYPE_Q, 16'h0000, 2'h0, 32'h0000_0001, 1'b0);
    cmd(tsc_pkg::OP_IN_CNT_CLR, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_IN_CNT_Q, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
  endtask

  task automatic test_output;
    int n;
    cmd(tsc_pkg::OP_OUTPUT_PULSE_LENGTH_SET, 16'h0001, 2'h0, 32'h0000_0000, 1'b0);
    fire(1'b0, 0);
    repeat (30) @(negedge core_clk);
    cmd(tsc_pkg::OP_OUT_CNT_Q, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_OUT_STATE_SET, 16'h0001, 2'h0, 32'h0000_0000, 1'b0);
    fork
      fire(1'b0, 0);
      pulse_len(1'b0, n);
      begin
        repeat (8) @(negedge core_clk);
        fire(1'b0, 2);
      end
    join
    check(n, tsc_pkg::CYC_PER_US);
    cmd(tsc_pkg::OP_OUT_CNT_Q, 16'h0000, 2'h0, 32'h0000_0001, 1'b0);
    cmd(tsc_pkg::OP_OUT_TYPE_SET, 16'h0001, 2'h0, 32'h0000_0000, 1'b0);
    @(negedge core_clk);
    check({31'h0, trig_out_pin}, 32'h0000_0000);
    cmd(tsc_pkg::OP_CHPOS_SET, 16'h0002, 2'h1, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_CHPOS_Q, 16'h0000, 2'h1, 32'h0000_0002, 1'b0);
    fire(1'b0, 1);
    repeat (30) @(negedge core_clk);
    cmd(tsc_pkg::OP_OUT_CNT_Q, 16'h0000, 2'h0, 32'h0000_0001, 1'b0);
    fork
      fire(1'b1, 1);
      pulse_len(1'b1, n);
    join
    check(n, tsc_pkg::CYC_PER_US);
    cmd(tsc_pkg::OP_OUT_CNT_Q, 16'h0000, 2'h0, 32'h0000_0002, 1'b0);
    cmd(tsc_pkg::OP_OUT_CNT_CLR, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_OUT_CNT_Q, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
  endtask

  task automatic test_settings;
    cmd(tsc_pkg::OP_WLEN_SET, 16'h04eb, 2'h0, 32'h0000_0000, 1'b1);
    cmd(tsc_pkg::OP_WLEN_Q, 16'h0000, 2'h0, 32'h0000_060e, 1'b0);
    cmd(tsc_pkg::OP_WLEN_SET, 16'h0673, 2'h0, 32'h0000_0000, 1'b1);
    cmd(tsc_pkg::OP_WLEN_SET, 16'h04ec, 2'h0, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_WLEN_Q, 16'h0000, 2'h0, 32'h0000_04ec, 1'b0);
    cmd(tsc_pkg::OP_WLEN_SET, 16'h0672, 2'h0, 32'h0000_0000, 1'b0);
    check({16'h0, wavelength_nm}, 32'h0000_0672);
    cmd(tsc_pkg::OP_UNIT_SET, 16'h0003, 2'h0, 32'h0000_0000, 1'b1);
    cmd(tsc_pkg::OP_UNIT_SET, 16'h0002, 2'h0, 32'h0000_0000, 1'b0);
    check({30'h0, unit_sel}, 32'h0000_0002);
    cmd(tsc_pkg::OP_LOCK_SET, 16'h0001, 2'h0, 32'h0000_0000, 1'b0);
    check({31'h0, disp_remote}, 32'h0000_0001);
    cmd(tsc_pkg::OP_LOCK_Q, 16'h0000, 2'h0, 32'h0000_0001, 1'b0);
    for (int i = 0; i < 9; i++) begin
      mode_code = i[3:0];
      cmd(tsc_pkg::OP_MODE_Q, 16'h0000, 2'h0, i, 1'b0);
    end
  endtask

  task automatic test_status;
    cmd(tsc_pkg::OP_ANOM_MASK_SET, 16'h0004, 2'h0, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_ACT_MASK_SET, 16'h8000, 2'h0, 32'h0000_0000, 1'b0);
    @(negedge core_clk);
    anom_evt = 16'h0006;
    act_evt = 16'h8001;
    @(negedge core_clk);
    anom_evt = 16'h0000;
    act_evt = 16'h0000;
    repeat (2) @(negedge core_clk);
    check({30'h0, anom_summary, act_summary}, 32'h0000_0003);
    cmd(tsc_pkg::OP_ANOM_EVT_Q, 16'h0000, 2'h0, 32'h0000_0006, 1'b0);
    cmd(tsc_pkg::OP_ANOM_EVT_Q, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    cmd(tsc_pkg::OP_ACT_EVT_Q, 16'h0000, 2'h0, 32'h0000_8001, 1'b0);
    cmd(tsc_pkg::OP_ANOM_MASK_Q, 16'h0000, 2'h0, 32'h0000_0004, 1'b0);
    cmd(tsc_pkg::OP_ACT_MASK_Q, 16'h0000, 2'h0, 32'h0000_8000, 1'b0);
    check({31'h0, anom_summary}, 32'h0000_0000);
  endtask

  task automatic test_function;
    cmd(tsc_pkg::OP_ABORT, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    check({31'h0, func_run}, 32'h0000_0000);
    cmd(tsc_pkg::OP_RESTART, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    check({31'h0, func_run}, 32'h0000_0001);
    check({31'h0, func_restart}, 32'h0000_0001);
    cmd(tsc_pkg::OP_PAUSE, 16'h0000, 2'h0, 32'h0000_0000, 1'b0);
    check({31'h0, func_run}, 32'h0000_0000);
  endtask

  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    test_defaults();
    test_input();
    test_output();
    test_settings();
    test_status();
    test_function();
    summarize();
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    #(40 * 20000);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
